/* inc/actr_pkg.sv */
// Package for the converter calibration and test register bank.
// Assumes an 8-bit register access port with single-cycle read and write strobes.
package actr_pkg;

  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned VEC_DEPTH = 32;
  localparam int unsigned VEC_IDX_W = 5;
  localparam int unsigned CNT_W     = 12;

  // Register offsets
  localparam logic [11:0] CAL_CFG0_OFS = 12'h050;
  localparam logic [11:0] BG_CTRL_OFS  = 12'h057;
  localparam logic [11:0] PAT_OVR_OFS  = 12'h058;
  localparam logic [11:0] VEC_OFS      = 12'h05a;
  localparam logic [11:0] STAT_OFS     = 12'h05b;
  localparam logic [11:0] TCAL_OFS     = 12'h066;

  // Reset values
  localparam logic [7:0] CAL_CFG0_RST = 8'h06;
  localparam logic [7:0] BG_CTRL_RST  = 8'h10;
  localparam logic [7:0] PAT_OVR_RST  = 8'h00;
  localparam logic [7:0] TCAL_RST     = 8'h02;
  localparam logic [7:0] VEC_RST      = 8'h00;
  localparam logic [7:0] STAT_RSVD    = 8'h08;

  // Field positions
  localparam int unsigned VEC_EN_BIT   = 4;
  localparam int unsigned FG_TRIG_BIT  = 3;
  localparam int unsigned BG_RUN_BIT   = 1;
  localparam int unsigned PAT_EN_BIT   = 2;
  localparam int unsigned OVR_EN_BIT   = 1;
  localparam int unsigned STOPPED_BIT  = 1;
  localparam int unsigned FIRST_BIT    = 0;
  localparam int unsigned T_AUTO_BIT   = 0;

  // Calibration phase lengths in clock cycles, minus one
  localparam logic [11:0] FG_LAST  = 12'h3ff;
  localparam logic [11:0] TIM_LAST = 12'h07f;
  localparam logic [11:0] BG_LAST  = 12'h0ff;

  typedef enum logic [1:0] {
    ACTR_IDLE = 2'b00,
    ACTR_FG   = 2'b01,
    ACTR_TIM  = 2'b10,
    ACTR_BG   = 2'b11
  } actr_cal_e;

  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } actr_req_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } actr_rsp_s;

endpackage

/* core/actr_cal_seq.sv */
// Calibration sequencer: foreground, timing optimisation and background passes.
// Assumes rst_n is already synchronised to clk.
module actr_cal_seq (
  input  wire logic clk,           // System clock
  input  wire logic rst_n,         // Synchronised reset, active low
  input  wire logic fg_start,      // One-cycle foreground trigger
  input  wire logic bg_run,        // Background run control level
  input  wire logic t_auto,        // Timing optimisation arm
  output logic      running,       // Any calibration in progress
  output logic      first_done,    // First calibration finished
  output logic      timing_active  // Timing optimisation phase
);
  import actr_pkg::*;

  typedef struct packed {
    actr_cal_e  state;
    logic [11:0] cnt;
    logic        t_armed;
    logic        first;
  } actr_seq_s;

  actr_seq_s s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      ACTR_IDLE: begin
        if (bg_run) begin
          s_nxt.state = ACTR_BG;
          s_nxt.cnt   = '0;
        end
      end
      ACTR_FG: begin
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.cnt == FG_LAST) begin
          s_nxt.cnt = '0;
          if (s_r.t_armed) begin
            s_nxt.state = ACTR_TIM;
          end else begin
            s_nxt.first = 1'b1;
            s_nxt.state = bg_run ? ACTR_BG : ACTR_IDLE;
          end
        end
      end
      ACTR_TIM: begin
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.cnt == TIM_LAST) begin
          s_nxt.cnt     = '0;
          s_nxt.t_armed = 1'b0;
          s_nxt.first   = 1'b1;
          s_nxt.state   = bg_run ? ACTR_BG : ACTR_IDLE;
        end
      end
      ACTR_BG: begin
        // A pass completes unless retriggered, so the stop lags the clear of the run control
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.cnt == BG_LAST) begin
          s_nxt.cnt   = '0;
          s_nxt.first = 1'b1;
          if (!bg_run) begin
            s_nxt.state = ACTR_IDLE;
          end
        end
      end
      default: s_nxt.state = ACTR_IDLE;
    endcase
    // Trigger restarts the machine from any state
    if (fg_start) begin
      s_nxt.state   = ACTR_FG;
      s_nxt.cnt     = '0;
      s_nxt.t_armed = t_auto;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{state: ACTR_IDLE, cnt: 12'h000, t_armed: 1'b0, first: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign running       = (s_r.state != ACTR_IDLE);
  assign first_done    = s_r.first;
  assign timing_active = (s_r.state == ACTR_TIM);

endmodule // actr_cal_seq

/* core/actr_regs.sv */
// Calibration and test register bank with calibration vector store.
// Assumes the serial front end delivers decoded one-cycle register strobes on clk.
//
// What this block does
// - Pattern register bit 2 enables the test pattern and bit 1 the over-range output, both reset to zero.
// - With vector access enabled, each read of the vector port returns the next stored calibration byte.
// - With vector access enabled, each write of the vector port loads the next calibration byte.
// - Status bit 1 reads 0 while any calibration runs and 1 once it has finished or stopped.
// - Status bit 0 sets once the first calibration sequence has completed.
// - Timing register bit 0 arms timing optimisation within the next triggered foreground calibration.
// - Configuration 0 bit 4 gates the vector port so that accesses leave the store untouched when clear.
// - Writing the trigger bit restarts the calibration machine with a foreground run and the bit self-clears.
// - Background run control starts background calibration when set and stops it at the end of the current pass when cleared.
module actr_regs (
  input  wire logic        clk,               // System clock, 125 MHz
  input  wire logic        reset_n,           // Asynchronous reset, active low
  input  wire actr_pkg::actr_req_s req,       // Register access strobes
  output actr_pkg::actr_rsp_s      rsp,       // Read data and valid
  output logic             test_pattern_enable,   // Converter outputs test pattern
  output logic             overrange_out_enable,  // Over-range indication enabled
  output logic             cal_running,       // Calibration in progress
  output logic             timing_opt_active, // Timing optimisation phase
  output logic             first_cal_done     // Converter operational
);
  import actr_pkg::*;

  typedef struct packed {
    logic [7:0]           cfg0;
    logic [7:0]           bg_ctrl;
    logic [7:0]           pat;
    logic [7:0]           tcal;
    logic [VEC_IDX_W-1:0] idx;
    logic [7:0]           rdata;
    logic                 rvalid;
  } actr_regs_s;

  actr_regs_s s_r, s_nxt;
  logic [7:0] vec_mem [VEC_DEPTH];
  logic       rst_meta_r;
  logic       rst_sync_r;
  logic       vec_en;
  logic       vec_wr;
  logic       fg_start;
  logic       seq_running;
  logic       seq_first;
  logic [7:0] stat_val;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign vec_en   = s_r.cfg0[VEC_EN_BIT];
  assign vec_wr   = req.wr && (req.addr == VEC_OFS) && vec_en;
  assign fg_start = req.wr && (req.addr == CAL_CFG0_OFS) && req.wdata[FG_TRIG_BIT];

  always_comb begin
    stat_val = STAT_RSVD;
    stat_val[STOPPED_BIT] = !seq_running;
    stat_val[FIRST_BIT]   = seq_first;
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = req.rd;
    if (req.wr) begin
      if (req.addr == CAL_CFG0_OFS) begin
        s_nxt.cfg0 = req.wdata;
        s_nxt.cfg0[FG_TRIG_BIT] = 1'b0;
        if (req.wdata[VEC_EN_BIT] && !vec_en) begin
          s_nxt.idx = '0;
        end
      end else if (req.addr == BG_CTRL_OFS) begin
        s_nxt.bg_ctrl = req.wdata;
      end else if (req.addr == PAT_OVR_OFS) begin
        s_nxt.pat = req.wdata;
      end else if (req.addr == TCAL_OFS) begin
        s_nxt.tcal = req.wdata;
      end else if (vec_wr) begin
        s_nxt.idx = s_r.idx + 1'b1;
      end
    end
    if (req.rd) begin
      if (req.addr == CAL_CFG0_OFS) begin
        s_nxt.rdata = s_r.cfg0;
      end else if (req.addr == BG_CTRL_OFS) begin
        s_nxt.rdata = s_r.bg_ctrl;
      end else if (req.addr == PAT_OVR_OFS) begin
        s_nxt.rdata = s_r.pat;
      end else if (req.addr == TCAL_OFS) begin
        s_nxt.rdata = s_r.tcal;
      end else if (req.addr == STAT_OFS) begin
        s_nxt.rdata = stat_val;
      end else if (req.addr == VEC_OFS) begin
        // Closed port reads zero and leaves the index alone
        if (vec_en) begin
          s_nxt.rdata = vec_mem[s_r.idx];
          s_nxt.idx   = s_r.idx + 1'b1;
        end else begin
          s_nxt.rdata = VEC_RST;
        end
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_r <= '{cfg0: CAL_CFG0_RST, bg_ctrl: BG_CTRL_RST, pat: PAT_OVR_RST, tcal: TCAL_RST,
               idx: '0, rdata: 8'h00, rvalid: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Store has no reset: contents are only meaningful once loaded through the vector port
  always_ff @(posedge clk) begin
    if (vec_wr) begin
      vec_mem[s_r.idx] <= req.wdata;
    end
  end

  actr_cal_seq u_seq (
    .clk           (clk),
    .rst_n         (rst_sync_r),
    .fg_start      (fg_start),
    .bg_run        (s_r.bg_ctrl[BG_RUN_BIT]),
    .t_auto        (s_r.tcal[T_AUTO_BIT]),
    .running       (seq_running),
    .first_done    (seq_first),
    .timing_active (timing_opt_active)
  );

  assign rsp.rdata            = s_r.rdata;
  assign rsp.rvalid           = s_r.rvalid;
  assign test_pattern_enable  = s_r.pat[PAT_EN_BIT];
  assign overrange_out_enable = s_r.pat[OVR_EN_BIT];
  assign cal_running          = seq_running;
  assign first_cal_done       = seq_first;

endmodule // actr_regs

/* sim/actr_regs_checker.sv */
// Port assertions for the calibration and test register bank.
// Assumes it is bound to actr_regs and sees only its ports.
module actr_regs_checker (
  input wire logic                clk,                  // Clock
  input wire logic                reset_n,              // Reset, active low
  input wire actr_pkg::actr_req_s req,                  // Requests
  input wire actr_pkg::actr_rsp_s rsp,                  // Answers
  input wire logic                test_pattern_enable,  // Pattern
  input wire logic                overrange_out_enable, // Over-range
  input wire logic                cal_running,          // Busy
  input wire logic                timing_opt_active,    // Timing phase
  input wire logic                first_cal_done        // Operational
);
  import actr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence pat_wr;
    req.wr && req.addr == PAT_OVR_OFS;
  endsequence
  sequence fg_trig;
    req.wr && req.addr == CAL_CFG0_OFS && req.wdata[FG_TRIG_BIT];
  endsequence
  chk_read_answer: assert property (req.rd |=> rsp.rvalid)
    else $error("read not answered");
  chk_pat_write: assert property (pat_wr |=> test_pattern_enable == $past(req.wdata[PAT_EN_BIT]) &&
    overrange_out_enable == $past(req.wdata[OVR_EN_BIT]))
    else $error("pattern register not taken");
  // A sequence cannot be negated in an antecedent, so the strobe is spelled out here
  chk_pat_hold: assert property (!(req.wr && req.addr == PAT_OVR_OFS) |=>
    $stable({test_pattern_enable, overrange_out_enable}))
    else $error("pattern outputs moved");
  chk_stat_read: assert property (req.rd && req.addr == STAT_OFS |=>
    rsp.rdata == {STAT_RSVD[7:2], !$past(cal_running), $past(first_cal_done)})
    else $error("status byte wrong");
  chk_fg_start: assert property (fg_trig |=> cal_running [*8])
    else $error("trigger did not start calibration");
  // Run control is registered first, so the sequencer leaves idle one cycle after the write lands
  chk_bg_start: assert property (req.wr && req.addr == BG_CTRL_OFS && req.wdata[BG_RUN_BIT] |=> ##1 cal_running)
    else $error("background run not started");
  chk_first_sticky: assert property (first_cal_done |=> first_cal_done)
    else $error("operational flag dropped");
  chk_tim_in_run: assert property (timing_opt_active |-> cal_running)
    else $error("timing phase outside calibration");
endmodule // actr_regs_checker

bind actr_regs actr_regs_checker u_chk (.clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp),
  .test_pattern_enable(test_pattern_enable), .overrange_out_enable(overrange_out_enable),
  .cal_running(cal_running), .timing_opt_active(timing_opt_active), .first_cal_done(first_cal_done));

/* sim/actr_regs_tb.sv */
// Self-checking bench for the calibration and test register bank.
// Assumes design and checker are compiled first; bench drives the strobe port.
module actr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import actr_pkg::*;
  logic       clk = 0;
  logic       reset_n = 0;
  actr_req_s  req = '0;
  actr_rsp_s  rsp;
  logic       pat, ovr, run, tim, fdone;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         seed = 32'hf11c4e2b;
  logic [7:0] rm [logic [11:0]];
  logic [7:0] mem [32];
  int         idx = 0;
  logic [7:0] d;
  always #4 clk = ~clk;
  actr_regs DUT (.clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp), .test_pattern_enable(pat),
    .overrange_out_enable(ovr), .cal_running(run), .timing_opt_active(tim), .first_cal_done(fdone));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Model follows each write once the design has taken it
  task automatic wr(logic [11:0] a, logic [7:0] v);
    @(posedge clk) req <= '{a, 1'b1, 1'b0, v};
    @(posedge clk) req.wr <= 1'b0;
    #1;
    if (a == VEC_OFS && rm[CAL_CFG0_OFS][VEC_EN_BIT]) begin
      mem[idx] = v;
      idx = (idx + 1) % 32;
    end else if (a == CAL_CFG0_OFS) begin
      if (v[VEC_EN_BIT] && !rm[a][VEC_EN_BIT]) idx = 0;
      rm[a] = v & 8'hf7;
    end else if (rm.exists(a)) rm[a] = v;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(posedge clk) req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk) req.rd <= 1'b0;
    #1 chk({7'h00, rsp.rvalid}, 8'h01);
    chk(rsp.rdata, e);
  endtask
  function automatic logic [7:0] mrd(logic [11:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == VEC_OFS && rm[CAL_CFG0_OFS][VEC_EN_BIT]) begin
      v = mem[idx];
      idx = (idx + 1) % 32;
    end else if (rm.exists(a)) v = rm[a];
    return v;
  endfunction
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    rm[CAL_CFG0_OFS] = CAL_CFG0_RST;
    rm[BG_CTRL_OFS] = BG_CTRL_RST;
    rm[PAT_OVR_OFS] = PAT_OVR_RST;
    rm[TCAL_OFS] = TCAL_RST;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rm[a]) rd(a, rm[a]);
    rd(VEC_OFS, 8'h00);
    rd(12'h123, 8'h00);
    // Idle after reset counts as stopped, and no calibration has finished yet
    rd(STAT_OFS, 8'h0a);
    chk({7'h00, fdone}, 8'h00);
    repeat (8) begin
      // Reserved bits are written as zero
      d = 8'($random(seed)) & 8'h06;
      wr(PAT_OVR_OFS, d);
      chk({6'h00, pat, ovr}, {6'h00, d[2], d[1]});
      rd(PAT_OVR_OFS, mrd(PAT_OVR_OFS));
    end
    // Disabled write must not land in the store
    wr(VEC_OFS, 8'h5c);
    wr(CAL_CFG0_OFS, 8'h16);
    for (int i = 0; i < 33; i++) wr(VEC_OFS, 8'($random(seed)));
    for (int i = 0; i < 32; i++) rd(VEC_OFS, mrd(VEC_OFS));
    wr(CAL_CFG0_OFS, 8'h06);
    rd(VEC_OFS, mrd(VEC_OFS));
    wr(CAL_CFG0_OFS, 8'h16);
    repeat (3) rd(VEC_OFS, mrd(VEC_OFS));
    wr(CAL_CFG0_OFS, 8'h0e);
    chk({7'h00, run}, 8'h01);
    rd(CAL_CFG0_OFS, mrd(CAL_CFG0_OFS));
    rd(STAT_OFS, 8'h08);
    repeat (1100) @(posedge clk);
    rd(STAT_OFS, 8'h0b);
    chk({7'h00, fdone}, 8'h01);
    wr(TCAL_OFS, 8'h03);
    wr(CAL_CFG0_OFS, 8'h0e);
    for (int i = 0; i < 1100 && tim !== 1'b1; i++) @(posedge clk);
    #1 chk({7'h00, tim}, 8'h01);
    for (int i = 0; i < 200 && run !== 1'b0; i++) @(posedge clk);
    #1 chk({6'h00, tim, run}, 8'h00);
    wr(BG_CTRL_OFS, 8'h12);
    rd(STAT_OFS, 8'h09);
    wr(BG_CTRL_OFS, 8'h10);
    // Stop lands only at the end of a pass, so wait on the busy flag
    for (int i = 0; i < 300 && run !== 1'b0; i++) @(posedge clk);
    rd(STAT_OFS, 8'h0b);
    wr(STAT_OFS, 8'hff);
    rd(STAT_OFS, 8'h0b);
    complete_run();
  end
endmodule // actr_regs_tb
